// ---- mau_defines.svh ----
`ifndef MAU_DEFINES_SVH
`define MAU_DEFINES_SVH

// operand address steps
`define MAU_LONG_STEP 32'h0000_0004
`define MAU_WORD_STEP 32'h0000_0002
// saturation bounds for the long form (upper word)
`define MAU_SAT48_MIN_HI 32'hFFFF8000
`define MAU_SAT48_MAX_HI 32'h00007FFF
// saturation bounds for the word form
`define MAU_SAT32_MIN 32'h80000000
`define MAU_SAT32_MAX 32'h7FFFFFFF
// reset values
`define MAU_RESET_WORD 32'h00000000
// return register load takes two states
`define MAU_RET_STATES 2

`endif

// ---- mau_pkg.sv ----
package mau_pkg;
   // operations issued by the decoder
   typedef enum logic [3:0] {
      MAU_OP_NONE,
      MAU_OP_LD_HIGH,
      MAU_OP_LD_LOW,
      MAU_OP_LD_RET,
      MAU_OP_LDM_HIGH,
      MAU_OP_LDM_LOW,
      MAU_OP_LDM_RET,
      MAU_OP_MAC_LONG,
      MAU_OP_MAC_WORD
   } mau_op_type;

   // data memory access sizes
   typedef enum logic [1:0] {
      MAU_SIZE_WORD,
      MAU_SIZE_LONG
   } mau_size_type;
endpackage

// ---- mau_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-stage reset release; assert asynchronous, release synchronous
module mau_sync (
   input wire logic clk,
   input wire logic rst_n,
   output logic rst_sync_n
);
   logic stage1_r;

   // ---------------------------------------------------------
   // reset release
   // ---------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_r <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         stage1_r <= 1'b1;
         rst_sync_n <= stage1_r;
      end
   end
endmodule
`default_nettype wire

// ---- mau_mult.sv ----
`timescale 1ns/1ps
`default_nettype none
// registered signed multiplier, 32x32 or sign-extended 16x16
module mau_mult (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic load,
   input wire logic word_mode,
   input wire logic [31:0] a,
   input wire logic [31:0] b,
   output logic [63:0] product_r
);
   logic signed [63:0] prod;

   // ---------------------------------------------------------
   // product
   // ---------------------------------------------------------
   always_comb begin
      if (word_mode) begin
         prod = 64'(signed'(a[15:0])) * 64'(signed'(b[15:0]));
      end else begin
         prod = 64'(signed'(a)) * 64'(signed'(b));
      end
   end

   // capture product when asked
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         product_r <= 64'h0000000000000000;
      end else if (ce && load) begin
         product_r <= prod;
      end
   end
endmodule
`default_nettype wire

// ---- mau_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mau_defines.svh"
// Summary of operation
// (RL1) register load copies source register to mac_high/mac_low in one state
// (RL2) post-increment load reads longword at source_gpr, then adds four
// (RL3) loads of procedure_return_reg take two execution states; MAU_OP_LDM_RET takes at least three (start, ST_LDM, ST_RET2)
// (RL4) mac_long_op multiplies two signed 32-bit memory operands, adds to acc
// (RL5) mac_long_op steps each operand address by four after its read
// (RL6) saturation clear: long result fills mac_high:mac_low as 64 bits
// (RL7) saturation set: long result clamps to 48-bit signed range
// (RL8) multiply-accumulate ops take two to five states, T bit untouched
// (RL9) mac_word_op multiplies two signed 16-bit operands, adds to acc
// (RL10) mac_word_op steps each operand address by two after its read
// (RL11) saturation clear: word product sign-extended into 64-bit acc
// (RL12) saturation set: word op saturates mac_low to 32-bit signed range
// (RL13) word saturation overflow sets bit 0 of mac_high
// (RL14) negative overflow gives minimum, positive overflow gives maximum
// (RL15) saturation flag sampled when each multiply-accumulate starts
// (RL16) memory port returns data before accumulation, stalling meanwhile
module mau_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic start,
   input wire mau_pkg::mau_op_type op,
   input wire logic [31:0] src_val,
   input wire logic [31:0] sec_val,
   input wire logic sat_flag,
   output logic busy,
   output logic done,
   output logic pc_advance,
   output logic t_write,
   output logic mem_req,
   output logic [31:0] mem_addr,
   output mau_pkg::mau_size_type mem_size,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   output logic gpr_src_we,
   output logic gpr_sec_we,
   output logic [31:0] gpr_wdata,
   output logic [31:0] mac_high_r,
   output logic [31:0] mac_low_r,
   output logic [31:0] ret_r
);
   import mau_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RET2, ST_LDM, ST_RD_SEC, ST_RD_SRC, ST_MUL, ST_ACC
   } mau_state_type;

   logic rst_s_n;
   mau_state_type state_r;
   mau_op_type op_r;
   logic sat_r;
   logic [31:0] src_addr_r;
   logic [31:0] sec_addr_r;
   logic [31:0] opnd_sec_r;
   logic [31:0] opnd_src_r;
   logic [31:0] step;
   logic is_word;
   logic [63:0] product;
   logic [63:0] acc_sum;
   logic [63:0] long_sat;
   logic [32:0] low_sum;
   logic [31:0] word_sat;
   logic word_ovf;

   mau_sync u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .rst_sync_n(rst_s_n)
   );

   mau_mult u_mult (
      .clk(clk),
      .rst_n(rst_s_n),
      .ce(ce),
      .load(state_r == ST_MUL),
      .word_mode(is_word),
      .a(opnd_sec_r),
      .b(opnd_src_r),
      .product_r(product)
   );

   // picks the operand from a fetch: a halfword for word ops, else all
   function automatic logic [31:0] fetch_val(input logic word_f,
      input logic [31:0] addr, input logic [31:0] d);
      if (word_f) begin
         fetch_val = addr[1] ? {16'h0000, d[15:0]} : {16'h0000, d[31:16]};
      end else begin
         fetch_val = d;
      end
   endfunction

   assign is_word = (op_r == MAU_OP_MAC_WORD);
   // (RL5) (RL10) address step per operand
   assign step = is_word ? `MAU_WORD_STEP : `MAU_LONG_STEP;

   // ---------------------------------------------------------
   // accumulate arithmetic
   // ---------------------------------------------------------
   // (RL11) (RL6) full 64-bit sum, word product already sign-extended
   assign acc_sum = {mac_high_r, mac_low_r} + product;

   // (RL7) 48-bit clamp on the sign-extended 48-bit accumulator
   always_comb begin
      logic signed [63:0] a48;
      logic signed [63:0] s48;
      a48 = 64'(signed'({mac_high_r[15:0], mac_low_r}));
      s48 = a48 + signed'(product);
      long_sat = {mac_high_r[31:16], s48[47:0]};
      if (s48 < signed'({`MAU_SAT48_MIN_HI, 32'h00000000})) begin
         long_sat = {mac_high_r[31:16], 16'(`MAU_SAT48_MIN_HI),
                     32'h00000000};
      end else if (s48 > signed'({`MAU_SAT48_MAX_HI, 32'hFFFFFFFF})) begin
         long_sat = {mac_high_r[31:16], 16'(`MAU_SAT48_MAX_HI),
                     32'hFFFFFFFF};
      end
   end

   // (RL12) (RL14) 32-bit saturating sum on mac_low only
   assign low_sum = {mac_low_r[31], mac_low_r} + {product[31], product[31:0]};
   assign word_ovf = low_sum[32] != low_sum[31];
   assign word_sat = !word_ovf ? low_sum[31:0] :
                     (low_sum[32] ? `MAU_SAT32_MIN : `MAU_SAT32_MAX);

   // ---------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         state_r <= ST_IDLE;
         op_r <= MAU_OP_NONE;
         sat_r <= 1'b0;
      end else if (ce) begin
         unique case (state_r)
            ST_IDLE: begin
               if (start) begin
                  op_r <= op;
                  // (RL15) saturation flag sampled at start
                  sat_r <= sat_flag;
                  unique case (op)
                     // (RL3) return load needs extra state
                     MAU_OP_LD_RET: state_r <= ST_RET2;
                     MAU_OP_LDM_HIGH, MAU_OP_LDM_LOW,
                     MAU_OP_LDM_RET: state_r <= ST_LDM;
                     MAU_OP_MAC_LONG,
                     MAU_OP_MAC_WORD: state_r <= ST_RD_SEC;
                     default: state_r <= ST_IDLE;
                  endcase
               end
            end
            ST_RET2: state_r <= ST_IDLE;
            // (RL16) wait for memory acknowledge
            ST_LDM: if (mem_ack) begin
               state_r <= (op_r == MAU_OP_LDM_RET) ? ST_RET2 : ST_IDLE;
            end
            ST_RD_SEC: if (mem_ack) begin
               state_r <= ST_RD_SRC;
            end
            ST_RD_SRC: if (mem_ack) begin
               state_r <= ST_MUL;
            end
            ST_MUL: state_r <= ST_ACC;
            ST_ACC: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // operand addresses and fetched data
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         src_addr_r <= `MAU_RESET_WORD;
         sec_addr_r <= `MAU_RESET_WORD;
         opnd_sec_r <= `MAU_RESET_WORD;
         opnd_src_r <= `MAU_RESET_WORD;
      end else if (ce) begin
         if (state_r == ST_IDLE && start) begin
            src_addr_r <= src_val;
            sec_addr_r <= sec_val;
         end
         if (state_r == ST_RD_SEC && mem_ack) begin
            opnd_sec_r <= fetch_val(is_word, sec_addr_r, mem_rdata);
         end
         if (state_r == ST_RD_SRC && mem_ack) begin
            opnd_src_r <= fetch_val(is_word, src_addr_r, mem_rdata);
         end
      end
   end

   // ---------------------------------------------------------
   // architectural registers
   // ---------------------------------------------------------
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         mac_high_r <= `MAU_RESET_WORD;
         mac_low_r <= `MAU_RESET_WORD;
         ret_r <= `MAU_RESET_WORD;
      end else if (ce) begin
         // (RL1) register load, one state
         if (state_r == ST_IDLE && start && op == MAU_OP_LD_HIGH) begin
            mac_high_r <= src_val;
         end
         if (state_r == ST_IDLE && start && op == MAU_OP_LD_LOW) begin
            mac_low_r <= src_val;
         end
         if (state_r == ST_IDLE && start && op == MAU_OP_LD_RET) begin
            ret_r <= src_val;
         end
         // (RL2) memory load into target register
         if (state_r == ST_LDM && mem_ack) begin
            unique case (op_r)
               MAU_OP_LDM_HIGH: mac_high_r <= mem_rdata;
               MAU_OP_LDM_LOW: mac_low_r <= mem_rdata;
               MAU_OP_LDM_RET: ret_r <= mem_rdata;
               default: ret_r <= ret_r;
            endcase
         end
         // (RL4) (RL9) accumulate the product
         if (state_r == ST_ACC) begin
            if (!sat_r) begin
               {mac_high_r, mac_low_r} <= acc_sum;
            end else if (!is_word) begin
               {mac_high_r, mac_low_r} <= long_sat;
            end else begin
               mac_low_r <= word_sat;
               // (RL13) overflow marker in mac_high
               if (word_ovf) begin
                  mac_high_r <= {mac_high_r[31:1], 1'b1};
               end
            end
         end
      end
   end

   // ---------------------------------------------------------
   // outputs to pipeline, memory and register file
   // ---------------------------------------------------------
   assign busy = (state_r != ST_IDLE);
   // (RL8) completion after fetches, multiply and accumulate
   // a low clock enable holds completion back with the state
   assign done = ce && ((state_r == ST_ACC) || (state_r == ST_RET2) ||
                 (state_r == ST_LDM && mem_ack && op_r != MAU_OP_LDM_RET) ||
                 (state_r == ST_IDLE && start &&
                  (op == MAU_OP_LD_HIGH || op == MAU_OP_LD_LOW)));
   assign pc_advance = done;
   // (RL8) the T bit is never written
   assign t_write = 1'b0;
   assign mem_req = (state_r == ST_LDM) || (state_r == ST_RD_SEC) ||
                    (state_r == ST_RD_SRC);
   assign mem_addr = (state_r == ST_RD_SEC) ? sec_addr_r : src_addr_r;
   assign mem_size = (state_r != ST_LDM && is_word) ?
                     MAU_SIZE_WORD : MAU_SIZE_LONG;
   // (RL2) (RL5) (RL10) post-increment write-back after each read
   assign gpr_src_we = ce && mem_ack && (state_r == ST_LDM ||
                                         state_r == ST_RD_SRC);
   assign gpr_sec_we = ce && mem_ack && (state_r == ST_RD_SEC);
   assign gpr_wdata = (state_r == ST_RD_SEC) ?
                      sec_addr_r + step :
                      src_addr_r + ((state_r == ST_LDM) ?
                                    `MAU_LONG_STEP : step);

   // ---------------------------------------------------------
   // checks
   // ---------------------------------------------------------
   sequence mac_start_s;
      state_r == ST_IDLE && start &&
      (op == MAU_OP_MAC_LONG || op == MAU_OP_MAC_WORD);
   endsequence

   ret_two_states_a: assert property (@(posedge clk) disable iff (!rst_s_n) // RL3
      (ce && state_r == ST_IDLE && start && op == MAU_OP_LD_RET) |=>
      (ce |-> done)) else $error("return load not two states");
   ld_high_copy_a: assert property (@(posedge clk) disable iff (!rst_s_n) // RL1
      (ce && state_r == ST_IDLE && start && op == MAU_OP_LD_HIGH) |=>
      mac_high_r == $past(src_val)) else $error("high load wrong");
   t_never_a: assert property (@(posedge clk) disable iff (!rst_s_n) // RL8
      !t_write) else $error("T bit written");
   mac_min_len_a: assert property (@(posedge clk) disable iff (!rst_s_n) // RL8
      (ce and mac_start_s) |=> !done) else $error("mac too short");
   sec_step_a: assert property (@(posedge clk) disable iff (!rst_s_n) // RL10
      (gpr_sec_we && is_word) |-> gpr_wdata == sec_addr_r + 32'h2)
      else $error("word step wrong");
   src_step_a: assert property (@(posedge clk) disable iff (!rst_s_n) // RL5
      (gpr_src_we && state_r == ST_RD_SRC && !is_word) |->
      gpr_wdata == src_addr_r + 32'h4) else $error("long step wrong");
   word_ovf_mark_a: assert property (@(posedge clk) disable iff (!rst_s_n) // RL13
      (ce && state_r == ST_ACC && sat_r && is_word && word_ovf) |=>
      mac_high_r[0]) else $error("overflow mark missing");
   word_sat_val_a: assert property (@(posedge clk) disable iff (!rst_s_n) // RL14
      (ce && state_r == ST_ACC && sat_r && is_word && word_ovf) |=>
      (mac_low_r == `MAU_SAT32_MIN || mac_low_r == `MAU_SAT32_MAX))
      else $error("saturated value wrong");
   mem_wait_a: assert property (@(posedge clk) disable iff (!rst_s_n) // RL16
      (mem_req && !mem_ack) |=>
      (mem_req && $stable(mem_addr) && $stable(mem_size)))
      else $error("request dropped");
endmodule
`default_nettype wire

// ---- mau_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// data memory stand-in: answers each request after lat idle cycles
module mau_mem_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] key,
   input wire logic [2:0] lat,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [2:0] wait_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_ack <= 1'b0;
         wait_r <= 3'h0;
         mem_rdata <= 32'h0;
      end else if (mem_req && !mem_ack && wait_r == lat) begin
         mem_ack <= 1'b1;
         wait_r <= 3'h0;
         mem_rdata <= mem_addr ^ key; // data tied to the address read
      end else begin
         mem_ack <= 1'b0;
         wait_r <= (mem_req && !mem_ack) ? wait_r + 3'h1 : 3'h0;
         mem_rdata <= ~mem_rdata; // stale data keeps moving
      end
   end
endmodule
`default_nettype wire

// ---- multiply_accumulate_unit_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module multiply_accumulate_unit_test;
   import mau_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic start = 1'b0;
   mau_op_type op = MAU_OP_NONE;
   logic [31:0] src_val = 32'h0, sec_val = 32'h0, key = 32'h0;
   logic sat_flag = 1'b0;
   logic [2:0] lat = 3'h0;
   logic busy, done, pc_advance, t_write, mem_req, mem_ack;
   logic gpr_src_we, gpr_sec_we;
   logic [31:0] mem_addr, mem_rdata, gpr_wdata, mac_high_r, mac_low_r, ret_r;
   mau_size_type mem_size;
   logic [31:0] mh = 32'h0, ml = 32'h0, mr = 32'h0, rnd = 32'h951C6C74;
   logic [31:0] r1, r2, r3;
   int n_fail = 0, checks = 0, tno = 0;

   // free-running 10 MHz clock
   always #50 clk = ~clk;

   mau_top uut (.clk(clk), .rst_n(rst_n), .ce(ce), .start(start), .op(op),
      .src_val(src_val), .sec_val(sec_val), .sat_flag(sat_flag),
      .busy(busy), .done(done), .pc_advance(pc_advance), .t_write(t_write),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_size(mem_size),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .gpr_src_we(gpr_src_we),
      .gpr_sec_we(gpr_sec_we), .gpr_wdata(gpr_wdata),
      .mac_high_r(mac_high_r), .mac_low_r(mac_low_r), .ret_r(ret_r));

   mau_mem_model mem (.clk(clk), .rst_n(rst_n), .mem_req(mem_req),
      .mem_addr(mem_addr), .key(key), .lat(lat), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));

   // ----------------------------------------
   // reference arithmetic and checks
   // ----------------------------------------
   function automatic logic [63:0] f_long(logic [31:0] h, l, a, b, logic sf);
      logic signed [63:0] p, v;
      p = $signed(a) * $signed(b);
      if (!sf)
         return {h, l} + p;
      v = $signed({h[15:0], l});
      v = v + p;
      if (v > 64'sh00007FFFFFFFFFFF)
         v = 64'sh00007FFFFFFFFFFF;
      if (v < 64'shFFFF800000000000)
         v = 64'shFFFF800000000000;
      return {h[31:16], v[47:0]};
   endfunction

   function automatic logic [63:0] f_word(logic [31:0] h, l,
         logic [15:0] a, b, logic sf);
      logic signed [63:0] p, w;
      p = $signed(a) * $signed(b);
      w = $signed(l) + p;
      if (!sf)
         return {h, l} + p;
      if (w > 64'sh000000007FFFFFFF)
         return {h | 32'h00000001, 32'h7FFFFFFF};
      if (w < 64'shFFFFFFFF80000000)
         return {h | 32'h00000001, 32'h80000000};
      return {h, w[31:0]};
   endfunction

   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
   endfunction

   task automatic draw(output logic [31:0] v);
      rnd = lfsr(rnd);
      v = rnd;
   endtask

   task automatic chk_val(logic [63:0] got, logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_cnt(int got, int exp);
      checks++;
      if (got != exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // one operation: issue, watch the ports, compare against the model
   task automatic do_op(mau_op_type o, logic [31:0] s, q, k, logic sf,
         logic [2:0] l);
      logic [63:0] e;
      logic [31:0] hs, hq, st, r;
      logic [32:0] wq[$], wg[$];
      logic [33:0] aq[$], ag[$];
      logic tw;
      int n, b;
      mau_size_type z;
      e = {mh, ml};
      r = mr;
      tw = 1'b0;
      z = (o == MAU_OP_MAC_WORD) ? MAU_SIZE_WORD : MAU_SIZE_LONG;
      hs = s[1] ? (s ^ k) : ((s ^ k) >> 16);
      hq = q[1] ? (q ^ k) : ((q ^ k) >> 16);
      st = (o == MAU_OP_MAC_WORD) ? 32'h2 : 32'h4;
      b = 1 + (o >= MAU_OP_LDM_HIGH) + (o == MAU_OP_LD_RET || o == MAU_OP_LDM_RET);
      case (o)
         MAU_OP_LD_HIGH: e[63:32] = s;
         MAU_OP_LD_LOW: e[31:0] = s;
         MAU_OP_LD_RET: r = s;
         MAU_OP_LDM_HIGH: e[63:32] = s ^ k;
         MAU_OP_LDM_LOW: e[31:0] = s ^ k;
         MAU_OP_LDM_RET: r = s ^ k;
         MAU_OP_MAC_LONG: e = f_long(mh, ml, q ^ k, s ^ k, sf);
         default: e = f_word(mh, ml, hq[15:0], hs[15:0], sf);
      endcase
      if (o >= MAU_OP_LDM_HIGH) begin
         aq.push_back({z, s});
         wq.push_back({1'b1, s + st});
      end
      if (o >= MAU_OP_MAC_LONG) begin
         aq.push_front({z, q});
         wq.push_front({1'b0, q + st});
      end
      @(negedge clk);
      start = 1'b1;
      op = o;
      src_val = s;
      sec_val = q;
      sat_flag = sf;
      key = k;
      lat = l;
      // cycle 1 is the start cycle; look mid-cycle once outputs settle
      for (n = 1; n < 60; n++) begin
         #10;
         if (gpr_src_we === 1'b1 || gpr_sec_we === 1'b1)
            wg.push_back({gpr_src_we, gpr_wdata});
         if (mem_ack === 1'b1)
            ag.push_back({mem_size, mem_addr});
         if (t_write !== 1'b0)
            tw = 1'b1;
         if (n == 2)
            chk_val(busy, 1'b1);
         if (done === 1'b1)
            break;
         @(negedge clk);
         start = 1'b0;
         sat_flag = ~sf; // flag must have been taken at the start edge
      end
      chk_val(pc_advance, 1'b1);
      chk_cnt(tw, 0);
      // each model read costs one turnaround cycle plus its latency
      if (o < MAU_OP_MAC_LONG)
         chk_cnt(n - ((o >= MAU_OP_LDM_HIGH) ? l + 1 : 0), b);
      else
         chk_cnt(n - 2 * (l + 1) >= 2 && n - 2 * (l + 1) <= 5, 1);
      @(negedge clk);
      start = 1'b0;
      chk_val(busy, 1'b0);
      chk_val({mac_high_r, mac_low_r}, e);
      chk_val(ret_r, r);
      chk_cnt(wg.size(), wq.size());
      foreach (wq[i]) chk_val(wg[i], wq[i]);
      chk_cnt(ag.size(), aq.size());
      foreach (aq[i]) chk_val(ag[i], aq[i]);
      mh = e[63:32];
      ml = e[31:0];
      mr = r;
      tno++;
      $display("test %0d op %0d ended", tno, o);
   endtask

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk_val({mac_high_r, mac_low_r}, 64'h0);
      chk_val({busy, done, ret_r}, 34'h0);
      do_op(MAU_OP_LD_HIGH, 32'h12340000, 32'h0, 32'h0, 1'b0, 3'h0);
      do_op(MAU_OP_LD_LOW, 32'hFFFFFFF0, 32'h0, 32'h0, 1'b0, 3'h0);
      do_op(MAU_OP_LD_RET, 32'h89ABCDEF, 32'h0, 32'h0, 1'b0, 3'h0);
      do_op(MAU_OP_LDM_RET, 32'hFFFFFFFC, 32'h0, 32'h0F0F0F0F, 1'b0, 3'h3);
      do_op(MAU_OP_MAC_LONG, 32'h0, 32'h0, 32'h7FFFFFFF, 1'b1, 3'h1);
      do_op(MAU_OP_MAC_LONG, 32'hFFFFFFFF, 32'h0, 32'h7FFFFFFF, 1'b1, 3'h0);
      do_op(MAU_OP_LD_LOW, 32'h7FFFFFFF, 32'h0, 32'h0, 1'b0, 3'h0);
      do_op(MAU_OP_MAC_WORD, 32'h0, 32'h2, 32'h7FFF7FFD, 1'b1, 3'h2);
      do_op(MAU_OP_LD_LOW, 32'h80000000, 32'h0, 32'h0, 1'b0, 3'h0);
      do_op(MAU_OP_MAC_WORD, 32'h0, 32'h2, 32'h7FFF8002, 1'b1, 3'h0);
      // clock enable low: a pending load must leave all state frozen
      @(negedge clk);
      ce = 1'b0;
      start = 1'b1;
      op = MAU_OP_LD_HIGH;
      src_val = 32'hA5A5A5A5;
      repeat (3) @(negedge clk);
      chk_val({done, busy}, 2'h0);
      chk_val({mac_high_r, mac_low_r}, {mh, ml});
      start = 1'b0;
      ce = 1'b1;
      repeat (60) begin
         draw(r1);
         draw(r2);
         draw(r3);
         do_op(mau_op_type'({1'b0, r1[2:0]} + 4'h1), r2, r3, r1 ^ r2, r1[8],
            {1'b0, r1[5:4]});
      end
      results();
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      results();
   end
endmodule
`default_nettype wire
